/* File: sdf_top.sv */
// sigma-delta decimation filter with gain, coding and apb control
//
// Summary of operation
// - modulator bit taken every 128 clocks
// - each modulator bit becomes a 40-bit word
// - notch equals clock over 512 times code
// - 11-bit notch code in control register
// - one new result per notch period
// - data valid three to four periods after change
// - gains 1..8 by multiple input sampling
// - gains 16..128 by digital shift
// - sample rate doubles per step, capped at eight
// - polarity bit only changes output coding
// - bit 4 drives burn-out source, reset clear
// - datapath headroom, saturate instead of wrap
// - gain held in control register
// - bipolar zero gives mid-scale code in offset binary, zero in twos complement
// - bipolar twos complement or offset binary
// - control register resets to 28B300
// - data ready low when new word available
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
module sdf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mod_bit_in,
    output logic mod_sample_strobe,
    output logic input_sample_strobe,
    output logic [1:0] gain_amplifier,
    output logic burnout_source_enable,
    output logic data_ready_n
);
    localparam int W = sdf_pkg::DATA_W;
    localparam int OW = sdf_pkg::OUT_W;
    localparam logic [6:0] MOD_LAST = 7'(sdf_pkg::MOD_DIV - 1);
    localparam logic signed [47:0] SAT_HI = 48'sh0000007FFFFF;
    localparam logic signed [47:0] SAT_LO = -48'sh000000800000;

    // register state
    logic [23:0] ctrl_r;
    logic [23:0] ctrl_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    // timing and datapath state
    logic sync1_r;
    logic sync2_r;
    logic sync1_nxt;
    logic sync2_nxt;
    logic [6:0] mod_cnt_r;
    logic [6:0] mod_cnt_nxt;
    logic [sdf_pkg::DEC_W-1:0] dec_cnt_r;
    logic [sdf_pkg::DEC_W-1:0] dec_cnt_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic tick_d1_r;
    logic tick_d1_nxt;
    logic tick_d2_r;
    logic tick_d2_nxt;
    logic vld_r;
    logic vld_nxt;
    logic [OW-1:0] dout_r;
    logic [OW-1:0] dout_nxt;
    logic rdy_n_r;
    logic rdy_n_nxt;

    logic setup;
    logic access;
    logic ctrl_wr;
    logic data_rd;
    logic mapped;
    logic mod_tick;
    logic dec_tick;
    logic resync;
    logic [sdf_pkg::CODE_W-1:0] code_raw;
    logic [sdf_pkg::CODE_W-1:0] code;
    logic [sdf_pkg::DEC_W-1:0] ratio;
    logic [2:0] gain_code;
    logic [1:0] front_gain;
    logic [2:0] digital_shift;
    logic [6:0] sample_mask;
    logic bipolar;
    logic offbin;
    logic [W-1:0] expanded;
    logic [W-1:0] integ0;
    logic [W-1:0] integ1;
    logic [W-1:0] integ2;
    logic [W-1:0] comb0;
    logic [W-1:0] comb1;
    logic [W-1:0] comb2;
    logic [3:0] bits_ratio;
    logic signed [7:0] net_shift;
    logic signed [47:0] wide;
    logic signed [47:0] scaled;
    logic signed [47:0] clamped;

    // control fields
    // notch code field
    assign code_raw = ctrl_r[sdf_pkg::CODE_LSB +: sdf_pkg::CODE_W];
    // out-of-range codes are pulled up so the decimator never stalls
    assign code = (code_raw < sdf_pkg::CODE_MIN) ? sdf_pkg::CODE_MIN : code_raw;
    assign ratio = sdf_pkg::DEC_W'({2'h0, code} * sdf_pkg::DEC_PER_CODE);
    assign gain_code = ctrl_r[sdf_pkg::GAIN_LSB +: 3];
    assign front_gain = (gain_code > sdf_pkg::FRONT_GAIN_MAX) ? 2'h3 : gain_code[1:0];
    assign digital_shift = (gain_code > sdf_pkg::FRONT_GAIN_MAX) ? gain_code - sdf_pkg::FRONT_GAIN_MAX : 3'h0;
    assign bipolar = ctrl_r[sdf_pkg::BIPOLAR_BIT];
    assign offbin = ctrl_r[sdf_pkg::OFFBIN_BIT];
    assign gain_amplifier = front_gain;
    assign burnout_source_enable = ctrl_r[sdf_pkg::BURNOUT_BIT];

    // apb decode, zero wait states
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == sdf_pkg::ADDR_CTRL) || (paddr == sdf_pkg::ADDR_DATA) || (paddr == sdf_pkg::ADDR_STAT);
    assign ctrl_wr = access && pwrite && (paddr == sdf_pkg::ADDR_CTRL);
    assign data_rd = access && !pwrite && (paddr == sdf_pkg::ADDR_DATA);
    assign pready = 1'b1;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    // any control write restarts the filter, as a setup change
    assign resync = ctrl_wr;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            for (int b = 0; b < 3; b++) begin
                if (pstrb[b]) begin
                    ctrl_nxt[8*b +: 8] = pwdata[8*b +: 8] & sdf_pkg::CTRL_MASK[8*b +: 8];
                end
            end
        end
    end

    // read data is captured in the setup phase so it is a flop in access
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pslverr_nxt = !mapped;
            unique case (paddr)
                sdf_pkg::ADDR_CTRL: prdata_nxt = {8'h00, ctrl_r};
                sdf_pkg::ADDR_DATA: prdata_nxt = {8'h00, dout_r};
                sdf_pkg::ADDR_STAT: begin
                    prdata_nxt = 32'h00000000;
                    prdata_nxt[sdf_pkg::STAT_READY_BIT] = !rdy_n_r;
                    prdata_nxt[sdf_pkg::STAT_SETTLE_BIT] = (settle_r != 2'h0);
                end
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= sdf_pkg::CTRL_RESET;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // modulator bit comes from the analog side: two flops first
    always_comb begin
        sync1_nxt = mod_bit_in;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    assign mod_tick = (mod_cnt_r == MOD_LAST);
    assign mod_sample_strobe = mod_tick;
    // input sampling 1, 2, 4 or 8 times per modulator cycle
    assign sample_mask = MOD_LAST >> front_gain;
    assign input_sample_strobe = ((mod_cnt_r & sample_mask) == sample_mask);
    assign dec_tick = mod_tick && (dec_cnt_r == ratio - 13'h0001);

    always_comb begin
        mod_cnt_nxt = mod_cnt_r + 7'h01;
        dec_cnt_nxt = dec_cnt_r;
        if (resync) begin
            dec_cnt_nxt = 13'h0000;
        end else if (mod_tick) begin
            dec_cnt_nxt = dec_tick ? 13'h0000 : dec_cnt_r + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_cnt_r <= 7'h00;
            dec_cnt_r <= 13'h0000;
        end else begin
            mod_cnt_r <= mod_cnt_nxt;
            dec_cnt_r <= dec_cnt_nxt;
        end
    end

    // one bit becomes plus or minus one, 40 bits wide
    assign expanded = sync2_r ? 40'h0000000001 : 40'hFFFFFFFFFF;

    sdf_integrator #(.W(W)) u_int0 (
        .pclk(pclk), .presetn(presetn), .en(mod_tick), .clr(resync), .din(expanded), .dout(integ0)
    );
    sdf_integrator #(.W(W)) u_int1 (
        .pclk(pclk), .presetn(presetn), .en(mod_tick), .clr(resync), .din(integ0), .dout(integ1)
    );
    sdf_integrator #(.W(W)) u_int2 (
        .pclk(pclk), .presetn(presetn), .en(mod_tick), .clr(resync), .din(integ1), .dout(integ2)
    );
    // combs at output rate
    // combs step one cycle apart so each sees fresh input; a shared enable would add two periods of lag
    sdf_comb #(.W(W)) u_comb0 (
        .pclk(pclk), .presetn(presetn), .en(dec_tick), .clr(resync), .din(integ2), .dout(comb0)
    );
    sdf_comb #(.W(W)) u_comb1 (
        .pclk(pclk), .presetn(presetn), .en(tick_d1_r), .clr(resync), .din(comb0), .dout(comb1)
    );
    sdf_comb #(.W(W)) u_comb2 (
        .pclk(pclk), .presetn(presetn), .en(tick_d2_r), .clr(resync), .din(comb1), .dout(comb2)
    );

    // bit length of the ratio sets the full-scale exponent, once per stage, three stages
    always_comb begin
        bits_ratio = 4'h0;
        for (int i = 0; i < sdf_pkg::DEC_W; i++) begin
            if (ratio[i]) begin
                bits_ratio = 4'(i + 1);
            end
        end
    end

    // gain then normalise to 24 bits with rounding
    // power-of-two normalisation trades exact full scale for no divider
    always_comb begin
        net_shift = 8'sd23 - 8'(signed'({4'h0, bits_ratio}) * 3) + 8'(signed'({5'h0, digital_shift}));
        wide = 48'(signed'(comb2));
        scaled = wide;
        if (net_shift >= 0) begin
            scaled = wide <<< net_shift;
        end else begin
            scaled = (wide + (48'sh1 <<< (-net_shift - 1))) >>> (-net_shift);
        end
        // saturate rather than wrap past the headroom
        clamped = scaled;
        if (scaled > SAT_HI) begin
            clamped = SAT_HI;
        end else if (scaled < SAT_LO) begin
            clamped = SAT_LO;
        end
    end

    // polarity affects only this coding step
    always_comb begin
        dout_nxt = dout_r;
        if (vld_r && (settle_r == 2'h0)) begin
            if (bipolar) begin
                // zero maps to mid-scale in offset binary
                // offset binary flips the sign bit
                dout_nxt = offbin ? (clamped[OW-1:0] ^ 24'h800000) : clamped[OW-1:0];
            end else begin
                // unipolar straight binary, negatives floor at zero
                dout_nxt = clamped[OW-1] ? 24'h000000 : {clamped[OW-2:0], 1'b0};
            end
        end
    end

    // discard outputs until the combs refill
    always_comb begin
        tick_d1_nxt = dec_tick && !resync;
        tick_d2_nxt = tick_d1_r && !resync;
        vld_nxt = tick_d2_r && !resync;
        settle_nxt = settle_r;
        rdy_n_nxt = rdy_n_r;
        if (resync) begin
            settle_nxt = sdf_pkg::SETTLE_CONV;
            rdy_n_nxt = 1'b1;
        end else begin
            if (data_rd) begin
                rdy_n_nxt = 1'b1;
            end
            if (vld_r) begin
                if (settle_r != 2'h0) begin
                    settle_nxt = settle_r - 2'h1;
                end else begin
                    // new word wins over a read clear
                    rdy_n_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d1_r <= 1'b0;
            tick_d2_r <= 1'b0;
            vld_r <= 1'b0;
            settle_r <= sdf_pkg::SETTLE_CONV;
            dout_r <= 24'h000000;
            rdy_n_r <= 1'b1;
        end else begin
            tick_d1_r <= tick_d1_nxt;
            tick_d2_r <= tick_d2_nxt;
            vld_r <= vld_nxt;
            settle_r <= settle_nxt;
            dout_r <= dout_nxt;
            rdy_n_r <= rdy_n_nxt;
        end
    end

    assign data_ready_n = rdy_n_r;
endmodule

/* File: sdf_pkg.sv */
// shared constants for the sigma-delta decimation filter
package sdf_pkg;
    localparam int DATA_W = 40;
    localparam int OUT_W = 24;
    localparam int CODE_W = 11;
    localparam int DEC_W = 13;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [23:0] CTRL_RESET = 24'h28B300;
    localparam logic [23:0] CTRL_MASK = 24'h7FF3F0;
    localparam int CODE_LSB = 12;
    localparam int OFFBIN_BIT = 9;
    localparam int BIPOLAR_BIT = 8;
    localparam int GAIN_LSB = 5;
    localparam int BURNOUT_BIT = 4;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_SETTLE_BIT = 1;
    localparam int MOD_DIV = 128;
    localparam int NOTCH_DIV = 512;
    localparam int DEC_PER_CODE = NOTCH_DIV / MOD_DIV;
    localparam logic [CODE_W-1:0] CODE_MIN = 11'h00A;
    localparam logic [CODE_W-1:0] CODE_MAX = 11'h7FF;
    localparam logic [1:0] SETTLE_CONV = 2'h3;
    localparam logic [2:0] FRONT_GAIN_MAX = 3'h3;
endpackage

/* File: sdf_integrator.sv */
// one wrapping integrator stage of the sinc3 decimator
`timescale 1ns/100ps
module sdf_integrator #(
    parameter int W = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic clr,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;

    // modular wrap is harmless: the combs cancel it
    always_comb begin
        acc_nxt = acc_r;
        if (clr) begin
            acc_nxt = '0;
        end else if (en) begin
            acc_nxt = acc_r + din;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign dout = acc_r;
endmodule

/* File: sdf_comb.sv */
// one differentiator stage of the sinc3 decimator, run at the output rate
`timescale 1ns/100ps
module sdf_comb #(
    parameter int W = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic clr,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] dly_r;
    logic [W-1:0] dly_nxt;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;

    always_comb begin
        dly_nxt = dly_r;
        out_nxt = out_r;
        if (clr) begin
            dly_nxt = '0;
            out_nxt = '0;
        end else if (en) begin
            dly_nxt = din;
            out_nxt = din - dly_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r <= '0;
            out_r <= '0;
        end else begin
            dly_r <= dly_nxt;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule

/* File: sdf_top_sva.sv */
// assertion checker for the decimation filter top
`timescale 1ns/100ps
module sdf_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mod_bit_in,
    input wire logic mod_sample_strobe,
    input wire logic input_sample_strobe,
    input wire logic [1:0] gain_amplifier,
    input wire logic burnout_source_enable,
    input wire logic data_ready_n
);
    logic [7:0] mcnt_r, mcnt_nxt;
    logic [3:0] icnt_r, icnt_nxt;
    logic [1:0] gprev_r;
    logic gchg_r, gchg_nxt;
    logic acc_cyc, mapped, ctrl_wr, data_rd;
    assign acc_cyc = psel && penable && pready;
    assign mapped = paddr == sdf_pkg::ADDR_CTRL || paddr == sdf_pkg::ADDR_DATA || paddr == sdf_pkg::ADDR_STAT;
    assign ctrl_wr = acc_cyc && pwrite && paddr == sdf_pkg::ADDR_CTRL;
    assign data_rd = acc_cyc && !pwrite && paddr == sdf_pkg::ADDR_DATA;
    // a window whose gain moved is not judged, the strobe count would be mixed
    always_comb begin
        mcnt_nxt = mod_sample_strobe ? 8'h00 : mcnt_r + 8'h01;
        icnt_nxt = mod_sample_strobe ? 4'h0 : icnt_r + {3'h0, input_sample_strobe};
        gchg_nxt = (mod_sample_strobe ? 1'b0 : gchg_r) || gain_amplifier != gprev_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcnt_r <= 8'h00;
            icnt_r <= 4'h0;
            gprev_r <= 2'h0;
            gchg_r <= 1'b1;
        end else begin
            mcnt_r <= mcnt_nxt;
            icnt_r <= icnt_nxt;
            gprev_r <= gain_amplifier;
            gchg_r <= gchg_nxt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mod_period: assert property (mod_sample_strobe |-> mcnt_r == 8'h7F)
        else $error("modulator strobe early");
    a_mod_due: assert property (mcnt_r == 8'h7F |-> mod_sample_strobe)
        else $error("modulator strobe missing");
    a_input_rate: assert property (mod_sample_strobe && !gchg_r && gain_amplifier == gprev_r |->
        {1'b0, icnt_r} + {4'h0, input_sample_strobe} == (5'h01 << gain_amplifier)) else $error("input rate wrong");
    a_gain_write: assert property (ctrl_wr && pstrb[0] |=> gain_amplifier ==
        ($past(pwdata[7:5]) >= 3'h3 ? 2'h3 : $past(pwdata[6:5]))) else $error("front gain wrong");
    a_burnout_write: assert property (ctrl_wr && pstrb[0] |=> burnout_source_enable == $past(pwdata[4]))
        else $error("burn-out bit wrong");
    a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_ready_resync: assert property (ctrl_wr |=> data_ready_n)
        else $error("ready kept across control write");
    a_ready_align: assert property ($fell(data_ready_n) |-> $past(mod_sample_strobe, 4))
        else $error("ready off modulator tick");
    a_ready_hold: assert property (!data_ready_n && !data_rd && !ctrl_wr |=> !data_ready_n)
        else $error("ready dropped unread");
    c_ctrl_write: cover property (ctrl_wr);
    c_new_word: cover property ($fell(data_ready_n));
    c_top_gain: cover property (input_sample_strobe && gain_amplifier == 2'h3);
endmodule
bind sdf_top sdf_top_sva sdf_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_bit_in(mod_bit_in), .mod_sample_strobe(mod_sample_strobe),
    .input_sample_strobe(input_sample_strobe), .gain_amplifier(gain_amplifier),
    .burnout_source_enable(burnout_source_enable), .data_ready_n(data_ready_n));

/* File: sdf_mod_model.sv */
// behavioural first-order modulator producing the one-bit stream
`timescale 1ns/100ps
module sdf_mod_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mod_sample_strobe,
    input wire logic [8:0] density,
    output logic mod_bit
);
    logic [9:0] sum;
    logic [7:0] acc;
    assign sum = {2'h0, acc} + {1'h0, density};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 8'h00;
            mod_bit <= 1'b0;
        end else if (mod_sample_strobe) begin
            mod_bit <= sum >= 10'h100;
            acc <= sum[7:0];
        end
    end
endmodule

/* File: test_sdf_top.sv */
// self-checking testbench for the decimation filter
`timescale 1ns/100ps
module test_sdf_top;
    localparam int PER = sdf_pkg::NOTCH_DIV * 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [8:0] density = 9'h080;
    logic [31:0] prdata, rd;
    logic [1:0] gain_amplifier;
    logic pready, pslverr, mod_bit_in, mod_sample_strobe, input_sample_strobe, burnout_source_enable;
    logic data_ready_n, er;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    sdf_top sdf_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_bit_in(mod_bit_in), .mod_sample_strobe(mod_sample_strobe), .input_sample_strobe(input_sample_strobe),
        .gain_amplifier(gain_amplifier), .burnout_source_enable(burnout_source_enable), .data_ready_n(data_ready_n));
    sdf_mod_model sdf_mod_model_inst (.pclk(pclk), .presetn(presetn), .mod_sample_strobe(mod_sample_strobe),
        .density(density), .mod_bit(mod_bit_in));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // results are approximate near zero, so a small window is allowed
    task automatic chk_near(input logic [23:0] got, input logic [23:0] exp, input logic [23:0] tol);
        logic [23:0] d;
        d = got - exp;
        check_count++;
        if (^got === 1'bx || (d > tol && d < 24'h000000 - tol)) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q,
        output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 50) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (data_ready_n !== 1'b0 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40000) begin
            n_errors++;
            end_sim();
        end
    endtask
    function automatic logic [31:0] cw(input logic [10:0] code, input logic ob, input logic bp,
        input logic [2:0] g, input logic bo);
        return {9'h000, code, 2'h0, ob, bp, g, bo, 4'h0};
    endfunction
    task automatic t_reset();
        apb(1'b0, sdf_pkg::ADDR_CTRL, 32'h0, rd, er);
        chk(rd, 32'h0028B300);
        chk({31'h0, burnout_source_enable}, 32'h0);
        chk({30'h0, gain_amplifier}, 32'h0);
        chk({31'h0, data_ready_n}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_regs();
        for (int g = 0; g < 8; g++) begin
            apb(1'b1, sdf_pkg::ADDR_CTRL, cw(11'h00A, 1'b1, 1'b1, g[2:0], g[0]), rd, er);
            repeat (260) @(posedge pclk);
            chk({30'h0, gain_amplifier}, g >= 3 ? 32'h3 : 32'(g));
            chk({31'h0, burnout_source_enable}, {31'h0, g[0]});
            apb(1'b0, sdf_pkg::ADDR_CTRL, 32'h0, rd, er);
            chk(rd, cw(11'h00A, 1'b1, 1'b1, g[2:0], g[0]));
        end
        apb(1'b1, sdf_pkg::ADDR_CTRL, 32'hFFFFFFFF, rd, er);
        apb(1'b0, sdf_pkg::ADDR_CTRL, 32'h0, rd, er);
        chk(rd, 32'h007FF3F0);
        pstrb <= 4'h1;
        apb(1'b1, sdf_pkg::ADDR_CTRL, 32'h0, rd, er);
        pstrb <= 4'hF;
        apb(1'b0, sdf_pkg::ADDR_CTRL, 32'h0, rd, er);
        chk(rd, 32'h007FF300);
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        $display("test registers done");
    endtask
    task automatic conversion_period();
        int n, t0;
        apb(1'b1, sdf_pkg::ADDR_CTRL, cw(11'h00A, 1'b1, 1'b1, 3'h0, 1'b0), rd, er);
        apb(1'b0, sdf_pkg::ADDR_STAT, 32'h0, rd, er);
        chk(rd, 32'h1 << sdf_pkg::STAT_SETTLE_BIT);
        wait_ready(n);
        t0 = cyc;
        chk(32'(n >= 3 * PER && n <= 4 * PER + 256), 32'h1);
        apb(1'b0, sdf_pkg::ADDR_STAT, 32'h0, rd, er);
        chk(rd, 32'h1 << sdf_pkg::STAT_READY_BIT);
        apb(1'b0, sdf_pkg::ADDR_DATA, 32'h0, rd, er);
        chk_near(rd[23:0], 24'h800000, 24'h000040);
        wait_ready(n);
        chk(32'(cyc - t0), 32'(PER));
        $display("test conversion rate done");
    endtask
    task automatic t_step();
        int n;
        logic [31:0] prev;
        apb(1'b1, sdf_pkg::ADDR_CTRL, cw(11'h00A, 1'b0, 1'b1, 3'h0, 1'b0), rd, er);
        wait_ready(n);
        apb(1'b0, sdf_pkg::ADDR_DATA, 32'h0, rd, er);
        chk_near(rd[23:0], 24'h000000, 24'h000040);
        density <= 9'h100;
        for (int i = 0; i < 5; i++) begin
            prev = rd;
            wait_ready(n);
            apb(1'b0, sdf_pkg::ADDR_DATA, 32'h0, rd, er);
        end
        chk(rd, prev);
        chk(32'(rd[23] == 1'b0 && rd[23:0] >= 24'h010000), 32'h1);
        $display("test step done");
    endtask
    task automatic t_unipolar();
        int n;
        density <= 9'h000;
        apb(1'b1, sdf_pkg::ADDR_CTRL, cw(11'h00A, 1'b0, 1'b0, 3'h0, 1'b0), rd, er);
        wait_ready(n);
        apb(1'b0, sdf_pkg::ADDR_DATA, 32'h0, rd, er);
        chk({8'h00, rd[23:0]}, 32'h0);
        $display("test unipolar done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        conversion_period();
        t_step();
        t_unipolar();
        end_sim();
    end
endmodule
